// ### core/hcf_front_regs.sv
// Front register group of the host controller with serial EEPROM byte port
//
// Contract
// - Version bits 31-25 and 15-8 read zero
// - Version bit 24 shows EEPROM detected, default zero
// - EEPROM present: load bus info block after reset
// - Version bits 23-16 read 01h
// - Version bits 7-0 read 10h
// - Chip resets clear resettable version bits
// - Bit 31 clears byte pointer, then self-clears
// - Pointer clear does not load byte zero
// - Bit 25 fetches current byte, self-clears when done
// - Fetched byte lands in bits 23-16
// - Read port bits 30-26, 24, 15-8 read zero
// - Option offset 00h, else loaded from 28h
// - Option offset valid only above 39h
// - Retry bits 31-16 read zero
// - Physical response unit retries up to bits 11-8
// - Transmit response unit retries up to bits 7-4
// - Transmit request unit retries up to bits 3-0
// - Retry bits 15-12 read zero
// - Swap data holds value for successful swap
// - Two-bit select picks swap resource
// - Done flag set at finish, cleared by write
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module hcf_front_regs
  import hcf_pkg::*;
#(
  parameter logic [7:0] BIB_BASE = 8'h00,
  parameter int         BIB_LEN  = 16
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Chip-level synchronous resets
  input  wire logic         express_fundamental_reset_in,
  input  wire logic         global_reset_in,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Serial EEPROM byte reader
  input  wire logic         eeprom_detect_in,
  output hcf_rom_req_t      rom_req,
  input  wire hcf_rom_rsp_t rom_rsp,
  // Bus info block stream after reset
  output hcf_bib_t          bib_out,
  // Status toward the rest of the controller
  output logic              eeprom_present_flag,
  output logic [7:0]        option_rom_offset,
  output logic              option_rom_valid,
  // Asynchronous transmit units, index 0 request, 1 response, 2 physical
  input  wire logic [2:0]   tx_begin,
  input  wire logic [2:0]   tx_fail,
  output logic [2:0]        tx_retry_go,
  output logic [2:0]        tx_give_up,
  output hcf_retry_t        retry_limits,
  // Compare-swap engine
  output logic [31:0]       swap_new_value,
  output logic [1:0]        swap_resource_select,
  output logic              swap_start,
  input  wire logic         swap_op_done
);

  // ==========================================================================
  // State
  typedef struct packed {
    hcf_fsm_t     fsm;
    logic         present;
    logic         clr;
    logic         go;
    logic [7:0]   ptr;
    logic [7:0]   fetched;
    logic [7:0]   offset;
    logic         offset_ok;
    logic [7:0]   bib_cnt;
    hcf_bib_t     bib;
    hcf_rom_req_t rom;
    hcf_retry_t   retry;
    logic [2:0][3:0] tries;
    logic [2:0]   retry_go;
    logic [2:0]   give_up;
    logic [31:0]  swap_data;
    logic         swap_done;
    logic [1:0]   swap_sel;
    logic         swap_start;
    logic         wr_pend;
    logic         rd_pend;
    logic [7:0]   addr;
    logic [31:0]  rdata;
  } hcf_state_t;

  hcf_state_t st;
  hcf_state_t next_st;

  logic            chip_reset;
  logic            accept;
  logic [2:0][3:0] next_tries;
  logic [2:0]      next_go;
  logic [2:0]      next_up;

  assign chip_reset = express_fundamental_reset_in | global_reset_in;
  assign accept     = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);

  // ==========================================================================
  // Read mux
  function automatic logic [31:0] read_mux(input hcf_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (s.addr)
      OFS_VERSION:   v = {7'h00, s.present, VER_MAJOR, 8'h00, VER_MINOR};
      OFS_READ_PORT: v = {s.clr, 5'h00, s.go, 1'b0, s.fetched, 8'h00, s.offset};
      OFS_RETRY:     v = {20'h0_0000, s.retry};
      OFS_SWAP_DATA: v = s.swap_data;
      OFS_SWAP_CTRL: v = {s.swap_done, 29'h0, s.swap_sel};
      default:       v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_mux

  // ==========================================================================
  // Retry counting per transmit unit
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_unit
      logic [3:0] lim;
      logic       more;
      assign lim  = st.retry[gi*4 +: 4];
      assign more = st.tries[gi] < lim;
      assign next_tries[gi] = tx_begin[gi] ? 4'h0
                            : (tx_fail[gi] && more) ? st.tries[gi] + 4'h1 : st.tries[gi];
      assign next_go[gi] = !tx_begin[gi] && tx_fail[gi] && more;
      assign next_up[gi] = !tx_begin[gi] && tx_fail[gi] && !more;
    end
  endgenerate

  // ==========================================================================
  // Next state
  always_comb begin
    next_st            = st;
    next_st.bib.valid  = 1'b0;
    next_st.swap_start = 1'b0;
    next_st.wr_pend    = 1'b0;
    next_st.tries      = next_tries;
    next_st.retry_go   = next_go;
    next_st.give_up    = next_up;

    // Reads take one wait state so a write just before is always seen
    if (st.rd_pend) begin
      next_st.rdata   = read_mux(st);
      next_st.rd_pend = 1'b0;
    end

    // Pointer clear only between fetches
    if (st.clr && st.fsm == ST_IDLE) begin
      next_st.ptr = 8'h00;
      next_st.clr = 1'b0;
    end

    case (st.fsm)
      ST_START: begin
        next_st.present = eeprom_detect_in;
        next_st.offset  = OFFSET_RST;
        if (eeprom_detect_in) begin
          next_st.fsm = ST_BOOT_MINI;
          next_st.rom = '{req: 1'b1, addr: MINI_ROM_ADDR};
        end else begin
          next_st.fsm = ST_IDLE;
        end
      end
      ST_BOOT_MINI: begin
        if (rom_rsp.ack) begin
          next_st.offset   = rom_rsp.data;
          next_st.rom.addr = BIB_BASE;
          next_st.bib_cnt  = 8'h00;
          next_st.fsm      = ST_BOOT_BIB;
        end
      end
      ST_BOOT_BIB: begin
        if (rom_rsp.ack) begin
          next_st.bib = '{valid: 1'b1, idx: st.bib_cnt, data: rom_rsp.data};
          if (st.bib_cnt == 8'(BIB_LEN - 1)) begin
            next_st.rom.req = 1'b0;
            next_st.fsm     = ST_IDLE;
          end else begin
            next_st.bib_cnt  = st.bib_cnt + 8'h01;
            next_st.rom.addr = st.rom.addr + 8'h01;
          end
        end
      end
      ST_IDLE: begin
        if (st.go && !st.clr) begin
          if (st.present) begin
            next_st.rom = '{req: 1'b1, addr: st.ptr};
            next_st.fsm = ST_FETCH;
          end else begin
            // Without a device a fetch finishes at once and leaves the byte alone
            next_st.go = 1'b0;
          end
        end
      end
      ST_FETCH: begin
        if (rom_rsp.ack) begin
          next_st.fetched = rom_rsp.data;
          next_st.ptr     = st.ptr + 8'h01;
          next_st.go      = 1'b0;
          next_st.rom.req = 1'b0;
          next_st.fsm     = ST_IDLE;
        end
      end
      default: next_st.fsm = ST_START;
    endcase

    // Write data phase; a set written now outlives a completion this cycle
    if (st.wr_pend) begin
      case (st.addr)
        OFS_READ_PORT: begin
          if (hwdata[BIT_CLEAR]) next_st.clr = 1'b1;
          if (hwdata[BIT_GO]) next_st.go = 1'b1;
        end
        OFS_RETRY:     next_st.retry = hwdata[11:0];
        OFS_SWAP_DATA: next_st.swap_data = hwdata;
        OFS_SWAP_CTRL: begin
          next_st.swap_sel   = hwdata[1:0];
          next_st.swap_done  = 1'b0;
          next_st.swap_start = 1'b1;
        end
        default: ;
      endcase
    end
    if (swap_op_done) next_st.swap_done = 1'b1;

    if (accept) begin
      next_st.addr    = haddr[7:0];
      next_st.wr_pend = hwrite;
      next_st.rd_pend = !hwrite;
    end

    if (chip_reset) begin
      next_st.present = 1'b0;
      next_st.offset  = OFFSET_RST;
      next_st.fsm     = ST_START;
      next_st.rom.req = 1'b0;
      next_st.clr     = 1'b0;
      next_st.go      = 1'b0;
    end
    // Registered so the validity flag never glitches while the offset reloads
    next_st.offset_ok = next_st.offset > MINI_ROM_MIN;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st           <= '0;
      st.swap_done <= SWAP_DONE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign hreadyout            = !st.rd_pend;
  assign hresp                = 1'b0;
  assign hrdata               = st.rdata;
  assign rom_req              = st.rom;
  assign bib_out              = st.bib;
  assign eeprom_present_flag  = st.present;
  assign option_rom_offset    = st.offset;
  assign option_rom_valid     = st.offset_ok;
  assign tx_retry_go          = st.retry_go;
  assign tx_give_up           = st.give_up;
  assign retry_limits         = st.retry;
  assign swap_new_value       = st.swap_data;
  assign swap_resource_select = st.swap_sel;
  assign swap_start           = st.swap_start;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_read_at(logic [7:0] ofs);
    accept && !hwrite && haddr[7:0] == ofs;
  endsequence

  sequence s_data_phase;
    !hreadyout ##1 hreadyout;
  endsequence

  a_version_read: assert property (s_read_at(OFS_VERSION) |-> ##1 s_data_phase ##0
    (hrdata[31:25] == 7'h00 && hrdata[23:16] == VER_MAJOR && hrdata[15:8] == 8'h00
     && hrdata[7:0] == VER_MINOR && hrdata[24] == $past(eeprom_present_flag)))
    else $error("version register read wrong");

  a_port_read: assert property (s_read_at(OFS_READ_PORT) |-> ##2
    (hrdata[30:26] == 5'h00 && !hrdata[24] && hrdata[15:8] == 8'h00))
    else $error("read port reserved bits not zero");

  a_retry_read: assert property (s_read_at(OFS_RETRY) |-> ##2 hrdata[31:12] == 20'h0_0000)
    else $error("retry register upper bits not zero");

  a_clear_done: assert property ((st.clr && st.fsm == ST_IDLE && !st.wr_pend && !chip_reset)
    |=> (st.ptr == 8'h00 && !st.clr))
    else $error("pointer clear did not complete");

  a_clear_noload: assert property ($changed(st.fetched) |-> $past(rom_rsp.ack && st.fsm == ST_FETCH))
    else $error("fetched byte changed without a fetch");

  a_fetch_lands: assert property ((st.fsm == ST_FETCH && rom_rsp.ack && !chip_reset)
    |=> (st.fetched == $past(rom_rsp.data) && st.fsm == ST_IDLE && !st.rom.req))
    else $error("fetched byte not stored");

  a_fetch_start: assert property ((st.fsm == ST_IDLE && st.go && !st.clr && st.present && !chip_reset)
    |=> (rom_req.req && rom_req.addr == $past(st.ptr)))
    else $error("fetch not started at pointer");

  a_boot_detect: assert property ((st.fsm == ST_START && !chip_reset)
    |=> (eeprom_present_flag == $past(eeprom_detect_in) && (st.fsm == ST_BOOT_MINI) == $past(eeprom_detect_in)))
    else $error("detect or boot load wrong");

  a_mini_load: assert property ((st.fsm == ST_BOOT_MINI && rom_rsp.ack && !chip_reset)
    |=> option_rom_offset == $past(rom_rsp.data))
    else $error("option offset not loaded");

  a_chip_reset: assert property (chip_reset |=> (!eeprom_present_flag && option_rom_offset == 8'h00))
    else $error("chip reset did not clear");

  a_req_giveup: assert property ((tx_fail[0] && !tx_begin[0] && st.tries[0] >= retry_limits.req)
    |=> (tx_give_up[0] && !tx_retry_go[0]))
    else $error("request unit retried past limit");

  a_resp_retry: assert property ((tx_fail[1] && !tx_begin[1] && st.tries[1] < retry_limits.resp)
    |=> (tx_retry_go[1] && st.tries[1] == $past(st.tries[1]) + 4'h1))
    else $error("response unit did not retry");

  a_phys_giveup: assert property ((tx_fail[2] && !tx_begin[2] && st.tries[2] >= retry_limits.phys)
    |=> tx_give_up[2])
    else $error("physical unit retried past limit");

  a_swap_data: assert property ((st.wr_pend && st.addr == OFS_SWAP_DATA) |=> swap_new_value == $past(hwdata))
    else $error("swap data not written");

  a_ctrl_write: assert property ((st.wr_pend && st.addr == OFS_SWAP_CTRL && !swap_op_done)
    |=> (!st.swap_done && swap_start && swap_resource_select == $past(hwdata[1:0])))
    else $error("control write wrong");

  a_done_set: assert property (swap_op_done |=> st.swap_done)
    else $error("done flag not set");

  a_go_selfclear: assert property ((st.fsm == ST_FETCH && rom_rsp.ack && !chip_reset
    && !(st.wr_pend && st.addr == OFS_READ_PORT && hwdata[BIT_GO])) |=> !st.go)
    else $error("fetch bit not cleared after fetch");

  a_retry_write: assert property ((st.wr_pend && st.addr == OFS_RETRY)
    |=> retry_limits == $past(hwdata[11:0]))
    else $error("retry limits not written");

  a_req_retry: assert property ((tx_fail[0] && !tx_begin[0] && st.tries[0] < retry_limits.req)
    |=> (tx_retry_go[0] && !tx_give_up[0]))
    else $error("request unit did not retry");

  a_phys_retry: assert property ((tx_fail[2] && !tx_begin[2] && st.tries[2] < retry_limits.phys)
    |=> (tx_retry_go[2] && st.tries[2] == $past(st.tries[2]) + 4'h1))
    else $error("physical unit did not retry");

endmodule : hcf_front_regs

`default_nettype wire

// ### core/hcf_pkg.sv
// Constants, field layouts and carrier types of the host controller front registers
package hcf_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_VERSION   = 8'h00;
  localparam logic [7:0] OFS_READ_PORT = 8'h04;
  localparam logic [7:0] OFS_RETRY     = 8'h08;
  localparam logic [7:0] OFS_SWAP_DATA = 8'h0C;
  localparam logic [7:0] OFS_SWAP_CTRL = 8'h14;

  // ==========================================================================
  // Field positions and constant field values
  localparam int         BIT_CLEAR     = 31;
  localparam int         BIT_GO        = 25;
  localparam logic [7:0] VER_MAJOR     = 8'h01;
  localparam logic [7:0] VER_MINOR     = 8'h10;
  localparam logic [7:0] MINI_ROM_ADDR = 8'h28;
  localparam logic [7:0] MINI_ROM_MIN  = 8'h39;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // ==========================================================================
  // Values after reset
  localparam logic       SWAP_DONE_RST = 1'b1;
  localparam logic [7:0] OFFSET_RST    = 8'h00;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_START     = 3'b000,
    ST_BOOT_MINI = 3'b001,
    ST_BOOT_BIB  = 3'b010,
    ST_IDLE      = 3'b011,
    ST_FETCH     = 3'b100
  } hcf_fsm_t;

  typedef struct packed {
    logic [3:0] phys;
    logic [3:0] resp;
    logic [3:0] req;
  } hcf_retry_t;

  typedef struct packed {
    logic       req;
    logic [7:0] addr;
  } hcf_rom_req_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] data;
  } hcf_rom_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] idx;
    logic [7:0] data;
  } hcf_bib_t;

endpackage : hcf_pkg

// ### verif/hcf_rom_model.sv
// Behavioural serial EEPROM answering the byte reader, promptly or slowly
`timescale 1ns/1ps
`default_nettype none

module hcf_rom_model
  import hcf_pkg::*;
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Behaviour controls
  input  wire logic         slow,
  input  wire logic [7:0]   mini_byte,
  // Byte reader link
  input  wire hcf_rom_req_t rom_req,
  output var  hcf_rom_rsp_t rom_rsp
);
  logic [2:0] waited;

  function automatic logic [7:0] byte_at(input logic [7:0] a);
    return (a == MINI_ROM_ADDR) ? mini_byte : a + 8'h30;
  endfunction : byte_at

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waited  <= 3'h0;
      rom_rsp <= '0;
    end else if (rom_req.req && !rom_rsp.ack && (!slow || waited == 3'h4)) begin
      rom_rsp <= {1'b1, byte_at(rom_req.addr)};
      waited  <= 3'h0;
    end else begin
      // Data only counts with ack; keep it moving so a stale byte is never trusted
      rom_rsp <= {1'b0, ~rom_rsp.data};
      waited  <= rom_req.req ? waited + 3'h1 : 3'h0;
    end
  end
endmodule : hcf_rom_model

`default_nettype wire

// ### verif/host_ctrl_front_regs_tb.sv
// Self-checking bench for the front register group with an EEPROM model
`timescale 1ns/1ps
`default_nettype none

module host_ctrl_front_regs_tb
  import hcf_pkg::*;
;
  localparam logic [7:0] BASE = 8'h10;
  localparam int         LEN  = 2;
  logic         clock, rst, efr_in, gr_in, hwrite, hreadyout, hresp, detect, slow;
  logic         present, opt_valid, swap_start, swap_done, rd_phase, rd_chk;
  logic [1:0]   htrans, sel;
  logic [31:0]  haddr, hwdata, hrdata, swap_val, rd, sw;
  logic [7:0]   opt_off, mini;
  logic [2:0]   tx_begin, tx_fail, retry_go, give_up;
  logic [11:0]  lim;
  hcf_rom_req_t rom_req;
  hcf_rom_rsp_t rom_rsp;
  hcf_bib_t     bib;
  hcf_retry_t   limits;
  int           failures, n_tests, n_start;
  logic [31:0]  exp_q[$];
  logic [15:0]  bib_q[$];
  logic [5:0]   rt_q[$];

  hcf_front_regs #(.BIB_BASE(BASE), .BIB_LEN(LEN)) dut (
    .clock(clock), .rst(rst), .express_fundamental_reset_in(efr_in), .global_reset_in(gr_in),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .eeprom_detect_in(detect), .rom_req(rom_req), .rom_rsp(rom_rsp), .bib_out(bib),
    .eeprom_present_flag(present), .option_rom_offset(opt_off), .option_rom_valid(opt_valid),
    .tx_begin(tx_begin), .tx_fail(tx_fail), .tx_retry_go(retry_go), .tx_give_up(give_up),
    .retry_limits(limits), .swap_new_value(swap_val), .swap_resource_select(sel),
    .swap_start(swap_start), .swap_op_done(swap_done));

  hcf_rom_model u_rom (.clock(clock), .rst(rst), .slow(slow), .mini_byte(mini), .rom_req(rom_req),
    .rom_rsp(rom_rsp));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ==========================================================================
  // Checking
  task automatic compare(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : compare

  task automatic give_verdict;
    // A note never matched by a result means an expected event went missing
    compare("pending notes", 0, 32'(exp_q.size() + bib_q.size() + rt_q.size()));
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic stall(input string what);
    compare(what, 1, 0);
    give_verdict();
  endtask : stall

  always @(posedge clock) begin
    if (rd_phase && rd_chk && hreadyout === 1'b1) begin
      compare("hresp", 0, hresp);
      if (exp_q.size() == 0) compare("read count", 0, 1);
      else compare("hrdata", exp_q.pop_front(), hrdata);
    end
    if (!rst && bib.valid === 1'b1) begin
      if (bib_q.size() == 0) compare("boot count", 0, 1);
      else compare("boot byte", bib_q.pop_front(), {bib.idx, bib.data});
    end
    if (!rst && (retry_go | give_up) !== 3'b000) begin
      if (rt_q.size() == 0) compare("retry count", 0, 1);
      else compare("retry pulse", rt_q.pop_front(), {retry_go, give_up});
    end
    if (swap_start === 1'b1) n_start++;
  end

  // ==========================================================================
  // Bus master
  task automatic wait_ready;
    for (int k = 0; k < 50; k++) begin
      @(posedge clock);
      if (hreadyout === 1'b1) return;
    end
    stall("hreadyout");
  endtask : wait_ready

  task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
  endtask : ahb_write

  task automatic ahb_read(input logic [7:0] a, input logic [31:0] e, input bit c, output logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'b10;
    wait_ready();
    htrans   <= 2'b00;
    rd_chk   <= c;
    rd_phase <= 1'b1;
    if (c) exp_q.push_back(e);
    wait_ready();
    d = hrdata;
    rd_phase <= 1'b0;
  endtask : ahb_read

  // ==========================================================================
  // Scenario helpers
  task automatic push_boot;
    for (int i = 0; i < LEN; i++) bib_q.push_back({i[7:0], u_rom.byte_at(BASE + i[7:0])});
  endtask : push_boot

  task automatic wait_boot;
    for (int k = 0; k < 300; k++) begin
      @(posedge clock);
      if (bib_q.size() == 0) return;
    end
    stall("boot");
  endtask : wait_boot

  task automatic fetch(input logic [31:0] cmd, input logic [7:0] b);
    ahb_write(OFS_READ_PORT, cmd);
    for (int k = 0; k < 40; k++) begin
      ahb_read(OFS_READ_PORT, 0, 0, rd);
      if (rd[BIT_CLEAR] === 1'b0 && rd[BIT_GO] === 1'b0) break;
      if (k == 39) stall("read port idle");
    end
    ahb_read(OFS_READ_PORT, {8'h00, b, 8'h00, mini}, 1, rd);
  endtask : fetch

  task automatic tx_try(input int i, input logic [5:0] e);
    rt_q.push_back(e);
    tx_fail <= 3'b001 << i;
    @(posedge clock);
    tx_fail <= 3'b000;
    repeat (2) @(posedge clock);
  endtask : tx_try

  // ==========================================================================
  // Main sequence
  initial begin
    {rst, detect} = 2'b11;
    {efr_in, gr_in, hwrite, slow, swap_done, rd_phase, rd_chk} = '0;
    {htrans, haddr, hwdata, tx_begin, tx_fail} = '0;
    {failures, n_tests, n_start} = '0;
    mini = 8'h5C;
    void'($urandom(32'hd6ea));
    push_boot();
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    wait_boot();
    compare("option offset", mini, opt_off);
    compare("offset valid", 1, opt_valid);
    ahb_write(OFS_VERSION, 32'hFFFF_FFFF);
    ahb_read(OFS_VERSION, {7'h0, 1'b1, VER_MAJOR, 8'h00, VER_MINOR}, 1, rd);
    ahb_read(8'h40, 32'h0, 1, rd);
    $display("test boot and version finished");
    compare("present flag", 1, present);
    fetch(32'h8200_0000, u_rom.byte_at(8'h00));
    slow <= 1'b1;
    fetch(32'h0200_0000, u_rom.byte_at(8'h01));
    fetch(32'h8000_0000, u_rom.byte_at(8'h01));
    fetch(32'h0200_0000, u_rom.byte_at(8'h00));
    slow <= 1'b0;
    $display("test eeprom port finished");
    tx_try(0, 6'b000_001);
    for (int i = 0; i < 3; i++) lim[4*i+:4] = 4'($urandom_range(4, 1));
    ahb_write(OFS_RETRY, ($urandom() & 32'hFFFF_F000) | {20'h0, lim});
    ahb_read(OFS_RETRY, {20'h0, lim}, 1, rd);
    compare("retry limits", {20'h0, lim}, {20'h0, limits});
    for (int i = 0; i < 3; i++) begin
      tx_begin <= 3'b001 << i;
      @(posedge clock);
      tx_begin <= 3'b000;
      @(posedge clock);
      for (int t = 0; t < lim[4*i+:4]; t++) tx_try(i, 6'b001_000 << i);
      tx_try(i, 6'b000_001 << i);
    end
    $display("test retry limits finished");
    ahb_read(OFS_SWAP_CTRL, 32'h8000_0000, 1, rd);
    sw = $urandom();
    ahb_write(OFS_SWAP_DATA, sw);
    ahb_read(OFS_SWAP_DATA, sw, 1, rd);
    compare("swap value", sw, swap_val);
    for (int s = 0; s < 4; s++) begin
      ahb_write(OFS_SWAP_CTRL, 32'(s));
      @(posedge clock);
      compare("swap select", 32'(s), {30'h0, sel});
      ahb_read(OFS_SWAP_CTRL, 32'(s), 1, rd);
      swap_done <= 1'b1;
      @(posedge clock);
      swap_done <= 1'b0;
      ahb_read(OFS_SWAP_CTRL, 32'h8000_0000 | 32'(s), 1, rd);
    end
    compare("swap starts", 4, n_start);
    $display("test compare swap finished");
    detect <= 1'b0;
    efr_in <= 1'b1;
    repeat (2) @(posedge clock);
    efr_in <= 1'b0;
    @(posedge clock);
    compare("present flag", 0, present);
    compare("option offset", 0, opt_off);
    ahb_read(OFS_VERSION, {8'h00, VER_MAJOR, 8'h00, VER_MINOR}, 1, rd);
    mini   <= 8'h39;
    detect <= 1'b1;
    @(posedge clock);
    push_boot();
    gr_in <= 1'b1;
    @(posedge clock);
    gr_in <= 1'b0;
    wait_boot();
    compare("present flag", 1, present);
    compare("option offset", 8'h39, opt_off);
    compare("offset valid", 0, opt_valid);
    $display("test chip resets finished");
    give_verdict();
  end
endmodule : host_ctrl_front_regs_tb

`default_nettype wire
